/* File: verilog/out_status_pkg.sv */
// shared constants and types for the output status signal block
package out_status_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] START_OFS    = 8'h04;
  localparam logic [7:0] CUR_THR_OFS  = 8'h08;
  localparam logic [7:0] PV_HIGH_OFS  = 8'h0c;
  localparam logic [7:0] PV_LOW_OFS   = 8'h10;
  localparam logic [7:0] TRIP_OFS     = 8'h14;
  localparam logic [7:0] LOGIC_OFS    = 8'h18;
  localparam logic [7:0] ROUTE_OFS    = 8'h1c;
  localparam logic [7:0] FLAGS_OFS    = 8'h20;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h24;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h28;

  // control register fields
  localparam int CTRL_MODBUS_BIT = 0;
  localparam int CTRL_CUR_SEL_BIT = 1;
  localparam int CTRL_STOP_BIT   = 2;

  // values after reset
  localparam logic [2:0]  CTRL_RST    = 3'h4;
  localparam logic [11:0] START_RST   = 12'h010;
  localparam logic [11:0] CUR_THR_RST = 12'h333;  // 4 mA on a 0..20 mA scale
  localparam logic [9:0]  PV_HIGH_RST = 10'h384;  // 90.0 %
  localparam logic [9:0]  PV_LOW_RST  = 10'h0c8;  // 20.0 %
  localparam logic [15:0] TRIP_RST    = 16'h0000;
  localparam logic [29:0] LOGIC_RST   = 30'h00000000;
  localparam logic [14:0] ROUTE_RST   = 15'h7fff;

  // field widths
  localparam int ROUTE_W = 5;
  localparam int LOGIC_W = 10;
  localparam int NUM_LOG = 3;
  localparam int NUM_EXT = 13;

  // routing select codes
  localparam logic [4:0] ROUTE_LOG_BASE = 5'h10;
  localparam logic [4:0] ROUTE_LOG_LAST = 5'h12;

  // timing: one millisecond timeout tick
  localparam int CLK_KHZ   = 20000;
  localparam int TICK_MS   = 1;
  localparam int TICK_CYC  = CLK_KHZ * TICK_MS;

  // operator encodings
  typedef enum logic [1:0] {
    OP_AND = 2'b00,
    OP_OR  = 2'b01,
    OP_XOR = 2'b10
  } logic_op_t;

  // live status flags
  typedef struct packed {
    logic [2:0] logic_out;
    logic       comm_loss;
    logic       second_stage;
    logic       analog_loss;
  } status_t;

  // routed terminal outputs
  typedef struct packed {
    logic relay;
    logic term_12;
    logic term_11;
  } terminals_t;

endpackage

/* File: verilog/out_status.sv */
// output terminal status logic with wishbone registers
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - voltage reference below start frequency flags loss
// - start frequency is the voltage loss threshold
// - current reference below 4 mA threshold flags loss
// - analog loss requests decelerate to stop
// - loss flag self clears, never trips
// - running with PV below low limit: stage on
// - PV above high limit turns stage off
// - run removed forces stage output off
// - PV limits in percent like setpoint
// - comm loss only with Modbus-RTU selected
// - comm loss held until next received data
// - timeout taken from trip time register
// - logic outputs combine two operands, one operator
// - logic output follows Boolean result
// - every status routable to terminals or relay
// - three independent logic outputs
module out_status
  import out_status_pkg::*;
#(
  parameter int TICK_CYCLES = out_status_pkg::TICK_CYC
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [7:0]                 adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [31:0]                dat_i,
  output logic      [31:0]                dat_o,
  output logic                            ack_o,
  input  wire logic [11:0]                v_ref_i,
  input  wire logic [11:0]                i_ref_i,
  input  wire logic [9:0]                 pv_i,
  input  wire logic                       forward_run_command_i,
  input  wire logic                       rx_data_strobe_i,
  input  wire logic [12:0]                ext_status_i,
  output out_status_pkg::status_t         status_o,
  output out_status_pkg::terminals_t      terminals_o,
  output logic                            decel_stop_o,
  output logic                            irq_o
);
  import out_status_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic [2:0]  ctrl;
    logic [11:0] start_freq;
    logic [11:0] cur_thr;
    logic [9:0]  pv_high;
    logic [9:0]  pv_low;
    logic [15:0] trip_ms;
    logic [29:0] logic_cfg;
    logic [14:0] route;
    logic [5:0]  irq_stat;
    logic [5:0]  irq_mask;
    logic [1:0]  run_sync;
    logic [14:0] tick_cnt;
    logic [15:0] idle_ms;
    status_t     flags;
    terminals_t  terms;
    logic        ack;
    logic [31:0] rdata;
  } state_t;

  state_t cur;
  state_t next_s;

  logic        running;
  logic        tick;
  logic        v_loss;
  logic        c_loss;
  logic        loss_now;
  logic        comm_now;
  logic        stage_now;
  logic [15:0] base_sig;
  logic [2:0]  log_now;
  logic [18:0] all_sig;
  logic        wr_hit;
  logic [31:0] rd_word;
  logic [31:0] wmask;
  status_t     flags_now;

  // apply byte enables to one register word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // evaluate one configured boolean output
  function automatic logic eval_log(input logic [LOGIC_W-1:0] cfg,
                                    input logic [15:0] sigs);
    logic a;
    logic b;
    a = sigs[cfg[3:0]];
    b = sigs[cfg[7:4]];
    unique case (cfg[9:8])
      OP_AND:  eval_log = a & b;
      OP_OR:   eval_log = a | b;
      OP_XOR:  eval_log = a ^ b;
      default: eval_log = 1'b0;  // unused operator code reads as off
    endcase
  endfunction

  // pick the signal routed to one terminal
  function automatic logic route_pick(input logic [ROUTE_W-1:0] s,
                                      input logic [18:0] sigs);
    if (s <= ROUTE_LOG_LAST) begin
      route_pick = sigs[s];
    end else begin
      route_pick = 1'b0;
    end
  endfunction

  // byte lane mask from wishbone select
  always_comb begin
    wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  end

  // synchronised run input and millisecond tick
  always_comb begin
    running = cur.run_sync[1];
    tick    = (cur.tick_cnt == 15'(TICK_CYCLES - 1));
  end

  // analog reference loss detection
  always_comb begin
    v_loss = (v_ref_i < cur.start_freq);
    c_loss = (i_ref_i < cur.cur_thr);
    loss_now = cur.ctrl[CTRL_CUR_SEL_BIT] ? c_loss : v_loss;
  end

  // second stage on/off with hysteresis
  always_comb begin
    stage_now = cur.flags.second_stage;
    if (!running) begin
      stage_now = 1'b0;
    end else if (pv_i < cur.pv_low) begin
      stage_now = 1'b1;
    end else if (pv_i > cur.pv_high) begin
      stage_now = 1'b0;
    end
  end

  // communication loss after reception timeout
  always_comb begin
    comm_now = cur.flags.comm_loss;
    if (rx_data_strobe_i) begin
      comm_now = 1'b0;
    end else if (cur.trip_ms != 16'h0000 && cur.idle_ms >= cur.trip_ms) begin
      comm_now = 1'b1;
    end
    if (!cur.ctrl[CTRL_MODBUS_BIT]) begin
      comm_now = 1'b0;
    end
  end

  // operand set excludes the logic outputs themselves
  always_comb begin
    base_sig = {ext_status_i, cur.flags.comm_loss, cur.flags.second_stage,
                cur.flags.analog_loss};
    for (int k = 0; k < NUM_LOG; k++) begin
      log_now[k] = eval_log(cur.logic_cfg[k*LOGIC_W +: LOGIC_W], base_sig);
    end
    all_sig = {cur.flags.logic_out, base_sig};
    flags_now.analog_loss  = loss_now;
    flags_now.second_stage = stage_now;
    flags_now.comm_loss    = comm_now;
    flags_now.logic_out    = log_now;
  end

  // register read mux
  always_comb begin
    rd_word = 32'h00000000;
    unique case (adr_i)
      CTRL_OFS:     rd_word = {29'h0, cur.ctrl};
      START_OFS:    rd_word = {20'h0, cur.start_freq};
      CUR_THR_OFS:  rd_word = {20'h0, cur.cur_thr};
      PV_HIGH_OFS:  rd_word = {22'h0, cur.pv_high};
      PV_LOW_OFS:   rd_word = {22'h0, cur.pv_low};
      TRIP_OFS:     rd_word = {16'h0, cur.trip_ms};
      LOGIC_OFS:    rd_word = {2'h0, cur.logic_cfg};
      ROUTE_OFS:    rd_word = {17'h0, cur.route};
      FLAGS_OFS:    rd_word = {23'h0, cur.terms, cur.flags};
      IRQ_STAT_OFS: rd_word = {26'h0, cur.irq_stat};
      IRQ_MASK_OFS: rd_word = {26'h0, cur.irq_mask};
      default:      rd_word = 32'h00000000;  // unmapped reads zero
    endcase
  end

  // next state
  always_comb begin
    logic [31:0] w;
    w      = 32'h00000000;
    next_s = cur;
    wr_hit = cyc_i && stb_i && we_i && cur.ack;

    // two-flop synchroniser for the run pin
    next_s.run_sync = {cur.run_sync[0], forward_run_command_i};

    // free running millisecond divider
    next_s.tick_cnt = tick ? 15'h0000 : cur.tick_cnt + 15'h0001;

    // idle time since last received data, saturating
    if (rx_data_strobe_i || !cur.ctrl[CTRL_MODBUS_BIT]) begin
      next_s.idle_ms = 16'h0000;
    end else if (tick && cur.idle_ms != 16'hffff) begin
      next_s.idle_ms = cur.idle_ms + 16'h0001;
    end

    next_s.flags = flags_now;

    // each terminal takes any status signal
    next_s.terms.term_11 = route_pick(cur.route[4:0], all_sig);
    next_s.terms.term_12 = route_pick(cur.route[9:5], all_sig);
    next_s.terms.relay   = route_pick(cur.route[14:10], all_sig);

    // single wait state: ack one cycle after request, then drop
    next_s.ack = cyc_i && stb_i && !cur.ack;
    if (cyc_i && stb_i && !cur.ack) begin
      next_s.rdata = rd_word;
    end

    // writes land on the edge where ack is seen high
    if (wr_hit) begin
      unique case (adr_i)
        CTRL_OFS: begin
          w = merge({29'h0, cur.ctrl}, dat_i, wmask);
          next_s.ctrl = w[2:0];
        end
        START_OFS: begin
          w = merge({20'h0, cur.start_freq}, dat_i, wmask);
          next_s.start_freq = w[11:0];
        end
        CUR_THR_OFS: begin
          w = merge({20'h0, cur.cur_thr}, dat_i, wmask);
          next_s.cur_thr = w[11:0];
        end
        PV_HIGH_OFS: begin
          w = merge({22'h0, cur.pv_high}, dat_i, wmask);
          next_s.pv_high = w[9:0];
        end
        PV_LOW_OFS: begin
          w = merge({22'h0, cur.pv_low}, dat_i, wmask);
          next_s.pv_low = w[9:0];
        end
        TRIP_OFS: begin
          w = merge({16'h0, cur.trip_ms}, dat_i, wmask);
          next_s.trip_ms = w[15:0];
        end
        LOGIC_OFS: begin
          w = merge({2'h0, cur.logic_cfg}, dat_i, wmask);
          next_s.logic_cfg = w[29:0];
        end
        ROUTE_OFS: begin
          w = merge({17'h0, cur.route}, dat_i, wmask);
          next_s.route = w[14:0];
        end
        IRQ_STAT_OFS: begin
          // write one to clear
          next_s.irq_stat = cur.irq_stat & ~(dat_i[5:0] & wmask[5:0]);
        end
        IRQ_MASK_OFS: begin
          w = merge({26'h0, cur.irq_mask}, dat_i, wmask);
          next_s.irq_mask = w[5:0];
        end
        default: begin
          w = 32'h00000000;  // read-only or unmapped: ignored
        end
      endcase
    end

    // rising edges of each flag set sticky bits; set beats clear
    next_s.irq_stat = next_s.irq_stat | (flags_now & ~cur.flags);
  end

  // single register stage for all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur            <= '0;
      cur.ctrl       <= CTRL_RST;
      cur.start_freq <= START_RST;
      cur.cur_thr    <= CUR_THR_RST;
      cur.pv_high    <= PV_HIGH_RST;
      cur.pv_low     <= PV_LOW_RST;
      cur.trip_ms    <= TRIP_RST;
      cur.logic_cfg  <= LOGIC_RST;
      cur.route      <= ROUTE_RST;
    end else begin
      cur <= next_s;
    end
  end

  // outputs straight from flops, irq is a level
  always_comb begin
    dat_o       = cur.rdata;
    ack_o       = cur.ack;
    status_o    = cur.flags;
    terminals_o = cur.terms;
    // loss asks the drive to ramp to stop
    decel_stop_o = cur.flags.analog_loss & cur.ctrl[CTRL_STOP_BIT];
    irq_o        = |(cur.irq_stat & cur.irq_mask);
  end

endmodule

/* File: tb/out_status_chk.sv */
// port assertions for the output status block
`timescale 1ns/1ps
module out_status_chk
  import out_status_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    cyc_i,
  input wire logic                    stb_i,
  input wire logic                    ack_o,
  input wire logic [9:0]              pv_i,
  input wire logic                    forward_run_command_i,
  input wire logic                    rx_data_strobe_i,
  input wire logic                    decel_stop_o,
  input wire out_status_pkg::status_t status_o
);
  // short aliases for the run pin and stage flag
  wire logic run = forward_run_command_i;
  wire logic stg = status_o.second_stage;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answer timing
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("late ack");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("long ack");
  // decel needs loss; run pin and pv limits govern the stage; 4 cycles cover the pin synchroniser
  a_decel_loss: assert property (decel_stop_o |-> status_o.analog_loss)
    else $error("decel without loss");
  a_stop_off: assert property (!run [*4] |=> !stg)
    else $error("stage on in stop");
  a_pv_high: assert property ((pv_i > PV_HIGH_RST) [*2] |=> !stg)
    else $error("stage on above high");
  a_pv_low: assert property ((run && pv_i < PV_LOW_RST) [*4] |=> stg)
    else $error("stage off below low");
  a_band_hold: assert property ((run && pv_i >= PV_LOW_RST && pv_i <= PV_HIGH_RST) [*4]
    |=> $stable(stg)) else $error("stage moved in band");
  // comm loss clears on data, otherwise stays
  a_rx_clear: assert property (rx_data_strobe_i |=> !status_o.comm_loss)
    else $error("loss kept after data");
  a_loss_hold: assert property (status_o.comm_loss && !rx_data_strobe_i |=> status_o.comm_loss)
    else $error("loss dropped early");
endmodule
bind out_status out_status_chk out_status_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .pv_i(pv_i),
  .forward_run_command_i(forward_run_command_i), .rx_data_strobe_i(rx_data_strobe_i),
  .decel_stop_o(decel_stop_o), .status_o(status_o));

/* File: tb/line_partner.sv */
// far-side serial peer: one received word per send request
`timescale 1ns/1ps
module line_partner (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic send_i,
  output logic      rx_strobe_o
);
  // each word is a one-cycle strobe
  always_ff @(posedge clk_i) begin
    rx_strobe_o <= !rst_i && send_i;
  end
endmodule

/* File: tb/out_status_bench.sv */
// self-checking bench for the output status block
`timescale 1ns/1ps
module out_status_bench;
  import out_status_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, run, send, rx, dec, irq;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o;
  logic [11:0] v_ref, i_ref;
  logic [9:0]  pv;
  logic [12:0] ext, e;
  logic [5:0]  st;
  logic [2:0]  tm;
  logic [31:0] x;
  logic [40:0] notes[$];
  logic [40:0] nt;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          seed = 99361;
  localparam logic [7:0] RA[9] = '{CTRL_OFS, START_OFS, CUR_THR_OFS, PV_HIGH_OFS,
    PV_LOW_OFS, TRIP_OFS, LOGIC_OFS, ROUTE_OFS, 8'h30};
  localparam logic [31:0] RV[9] = '{32'(CTRL_RST), 32'(START_RST), 32'(CUR_THR_RST),
    32'(PV_HIGH_RST), 32'(PV_LOW_RST), 32'(TRIP_RST), 32'(LOGIC_RST), 32'(ROUTE_RST), 32'h0};
  // run, expected stage, pv in tenths of a percent
  localparam logic [11:0] PVT[8] = '{12'hc64, 12'hdf4, 12'hb85, 12'h984, 12'h9f4,
    12'hcc7, 12'hf84, 12'h384};
  out_status #(.TICK_CYCLES(20)) out_status_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .v_ref_i(v_ref), .i_ref_i(i_ref), .pv_i(pv),
    .forward_run_command_i(run), .rx_data_strobe_i(rx), .ext_status_i(ext), .status_o(st),
    .terminals_o(tm), .decel_stop_o(dec), .irq_o(irq));
  line_partner line_partner_inst (.clk_i(clk_i), .rst_i(rst_i), .send_i(send),
    .rx_strobe_o(rx));
  task automatic chk(input logic [7:0] id, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch item %h expected %h seen %h", id, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled, then a gap cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    notes.push_back({c, a, d});
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 40) begin
      num_errors++;
      print_verdict();
    end
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, x, 1'b1);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // watcher: oldest note meets each acknowledged read
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt[40]) chk(nt[39:32], dat_o, nt[31:0]);
    end
  end
  // main sequence; flags word is {terminals, logic, comm, stage, analog}
  initial begin
    {rst_i, cyc_i, stb_i, we_i, run, send} = 6'h20;
    adr_i = 8'h00;
    dat_i = 32'h0;
    {v_ref, i_ref, pv, ext} = {12'h100, 12'h400, 10'h1f4, 13'h0};
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    for (int k = 0; k < 9; k++) rd(RA[k], RV[k]);
    wr(8'h30, 32'hffff);
    rd(8'h30, 32'h0);
    $display("register test done");
    v_ref <= START_RST - 12'h1;
    tick(4);
    rd(FLAGS_OFS, 32'h39);
    chk(8'hfe, dec, 1'b1);
    rd(IRQ_STAT_OFS, 32'h39);
    chk(8'hff, irq, 1'b0);
    wr(IRQ_MASK_OFS, 32'h1);
    tick(2);
    chk(8'hff, irq, 1'b1);
    wr(IRQ_STAT_OFS, 32'h39);
    tick(2);
    chk(8'hff, irq, 1'b0);
    v_ref <= START_RST;
    tick(4);
    rd(FLAGS_OFS, 32'h0);
    wr(CTRL_OFS, 32'h6);
    i_ref <= CUR_THR_RST - 12'h1;
    tick(4);
    rd(FLAGS_OFS, 32'h39);
    i_ref <= CUR_THR_RST;
    tick(4);
    rd(FLAGS_OFS, 32'h0);
    wr(CTRL_OFS, 32'h4);
    $display("analog loss test done");
    for (int k = 0; k < 8; k++) begin
      run <= PVT[k][11];
      pv <= PVT[k][9:0];
      tick(6);
      rd(FLAGS_OFS, {30'h0, PVT[k][10], 1'b0});
    end
    $display("second stage test done");
    wr(ROUTE_OFS, {17'h0, 5'h12, 5'h11, 5'h10});
    wr(LOGIC_OFS, {2'h0, 10'h265, 10'h154, 10'h043});
    for (int k = 0; k < 8; k++) begin
      e = 13'($random(seed));
      ext <= e;
      tick(5);
      x = {23'h0, {2{e[2] ^ e[3], e[1] | e[2], e[0] & e[1]}}, 3'h0};
      rd(FLAGS_OFS, x);
      chk(8'hfd, {23'h0, tm, st}, x);
    end
    // unused operator code reads off; terminals take plain status codes too
    wr(ROUTE_OFS, {17'h0, 5'h10, 5'h01, 5'h03});
    wr(LOGIC_OFS, {2'h0, 10'h265, 10'h154, 10'h333});
    ext <= 13'h1;
    tick(5);
    rd(FLAGS_OFS, 32'h40);
    chk(8'hfd, {23'h0, tm, st}, 32'h40);
    $display("logic output test done");
    ext <= 13'h0;
    wr(TRIP_OFS, 32'h2);
    tick(60);
    rd(FLAGS_OFS, 32'h0);
    wr(CTRL_OFS, 32'h5);
    tick(60);
    rd(FLAGS_OFS, 32'h4);
    send <= 1'b1;
    tick(1);
    send <= 1'b0;
    tick(6);
    rd(FLAGS_OFS, 32'h0);
    tick(50);
    rd(FLAGS_OFS, 32'h4);
    $display("comm loss test done");
    print_verdict();
  end
endmodule
